// file: rtl/krsw_pkg.sv
`default_nettype none
package krsw_pkg;

  // key lines width (4-bit key code)
  localparam int unsigned KEY_W = 4;

  // remote transfer: one nibble per strobe, nibbles per code
  localparam int unsigned NIB_COUNT   = 2;
  localparam logic [1:0]  NIB_LAST    = 2'h1;

  // clock rate and timing of the transfer clock toward the decoder
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned XFER_HALF_NS    = 400;
  localparam int unsigned XFER_HALF_CYC   = (XFER_HALF_NS * CLK_MHZ + 999) / 1000;
  // longest wait for a strobe before giving up
  localparam int unsigned STB_WAIT_US     = 4;
  localparam int unsigned STB_WAIT_CYC    = (STB_WAIT_US * CLK_MHZ);
  // key scan: settle time after the selector is switched
  localparam int unsigned SETTLE_NS       = 200;
  localparam int unsigned SETTLE_CYC      = (SETTLE_NS * CLK_MHZ + 999) / 1000;

  localparam int unsigned CNT_W = 12;

  // reset values of outputs
  localparam logic RST_SELECT = 1'b1;
  localparam logic RST_XCLK   = 1'b0;

  typedef enum logic [2:0] {
    KRSW_IDLE   = 3'b000,
    KRSW_SETTLE = 3'b001,
    KRSW_CLKHI  = 3'b011,
    KRSW_CLKLO  = 3'b010,
    KRSW_DONE   = 3'b110
  } krsw_state_type;

endpackage
`default_nettype wire

// file: rtl/krsw_sync.sv
`timescale 1ns/10ps
`default_nettype none
module krsw_sync
  import krsw_pkg::*;
#(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  // async in, synced out
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_reg;

  // two flops; first stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q_out    <= '0;
    end else if (clk_en) begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// file: rtl/krsw_top.sv
`timescale 1ns/10ps
`default_nettype none
module krsw_top
  import krsw_pkg::*;
(
  // clock, reset, enable
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             clk_en,
  // pins from the far side
  input  wire logic             notify_in,
  input  wire logic             remote_source_flag,
  input  wire logic             remote_timing_strobe,
  input  wire logic [KEY_W-1:0] key_lines,
  // pins toward the far side
  output logic                  source_select_output,
  output logic                  xfer_clock,
  // user side
  output logic [KEY_W-1:0]      code_data,
  output logic                  code_remote,
  output logic                  code_valid,
  output logic                  code_timeout
);

  logic                 rst_s1_reg;
  logic                 rst_n_reg;
  logic [KEY_W+2:0]     pin_raw;
  logic [KEY_W+2:0]     pin_s;
  logic                 notify_s;
  logic                 flag_s;
  logic                 stb_s;
  logic [KEY_W-1:0]     keys_s;
  logic                 notify_d_reg;
  logic                 stb_d_reg;
  logic                 notify_rise;
  logic                 stb_rise;
  krsw_state_type       state_reg;
  logic [CNT_W-1:0]     cnt_reg;
  logic [1:0]           nib_reg;
  logic [2*KEY_W-1:0]   shift_reg;

  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    return CNT_W'(n - 1);
  endfunction

  // reset release through two flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end

  // every pin crosses two flops before use
  assign pin_raw = {notify_in, remote_source_flag, remote_timing_strobe, key_lines};

  krsw_sync #(.W(KEY_W + 3)) u_sync (
    .clock (clock),
    .rst_n (rst_n_reg),
    .clk_en(clk_en),
    .d_in  (pin_raw),
    .q_out (pin_s)
  );

  assign notify_s = pin_s[KEY_W+2];
  assign flag_s   = pin_s[KEY_W+1];
  assign stb_s    = pin_s[KEY_W];
  assign keys_s   = pin_s[KEY_W-1:0];

  // edge detectors on synced copies
  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      notify_d_reg <= 1'b0;
      stb_d_reg    <= 1'b0;
    end else if (clk_en) begin
      notify_d_reg <= notify_s;
      stb_d_reg    <= stb_s;
    end
  end

  assign notify_rise = notify_s & ~notify_d_reg;
  assign stb_rise    = stb_s & ~stb_d_reg;

  // sequencer: notify edges outside idle are ignored, the flag only counts at the notify edge
  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg            <= KRSW_IDLE;
      cnt_reg              <= '0;
      nib_reg              <= '0;
      shift_reg            <= '0;
      source_select_output <= RST_SELECT;
      xfer_clock           <= RST_XCLK;
      code_data            <= '0;
      code_remote          <= 1'b0;
      code_valid           <= 1'b0;
      code_timeout         <= 1'b0;
    end else if (clk_en) begin
      code_valid   <= 1'b0;
      code_timeout <= 1'b0;
      case (state_reg)
        KRSW_IDLE: begin
          xfer_clock <= 1'b0;
          if (notify_rise) begin
            source_select_output <= ~flag_s;
            code_remote          <= flag_s;
            nib_reg              <= '0;
            cnt_reg              <= cyc(SETTLE_CYC);
            state_reg            <= KRSW_SETTLE;
          end
        end
        KRSW_SETTLE: begin
          // selector needs time to switch before lines are read
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else if (!code_remote) begin
            code_data  <= keys_s;
            code_valid <= 1'b1;
            state_reg  <= KRSW_DONE;
          end else begin
            xfer_clock <= 1'b1;
            cnt_reg    <= cyc(XFER_HALF_CYC);
            state_reg  <= KRSW_CLKHI;
          end
        end
        KRSW_CLKHI: begin
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else begin
            xfer_clock <= 1'b0;
            cnt_reg    <= cyc(STB_WAIT_CYC);
            state_reg  <= KRSW_CLKLO;
          end
        end
        KRSW_CLKLO: begin
          if (stb_rise) begin
            // data stands on key lines when strobe rises
            shift_reg <= {shift_reg[KEY_W-1:0], keys_s};
            if (nib_reg == NIB_LAST) begin
              code_data  <= keys_s;
              code_valid <= 1'b1;
              state_reg  <= KRSW_DONE;
            end else begin
              nib_reg    <= nib_reg + 2'h1;
              xfer_clock <= 1'b1;
              cnt_reg    <= cyc(XFER_HALF_CYC);
              state_reg  <= KRSW_CLKHI;
            end
          end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else begin
            // decoder silent: give up rather than hang
            code_timeout <= 1'b1;
            state_reg    <= KRSW_DONE;
          end
        end
        KRSW_DONE: begin
          // back to key scan; wait for notify low so a held level is no new edge
          source_select_output <= 1'b1;
          if (!notify_s) begin
            state_reg <= KRSW_IDLE;
          end
        end
        default: state_reg <= KRSW_IDLE;
      endcase
    end
  end

  // checks
  select_follows_flag_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
    (clk_en && state_reg == KRSW_IDLE && notify_rise) |=> (source_select_output == !$past(flag_s)))
    else $error("select output does not follow source flag");

  remote_code_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
    (clk_en && state_reg == KRSW_IDLE && notify_rise) |=> (code_remote == $past(flag_s)))
    else $error("source not taken from flag at notify edge");

  key_no_clock_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
    (!code_remote && state_reg != KRSW_IDLE) |-> !xfer_clock)
    else $error("transfer clock during key scan");

  clock_pulse_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
    (clk_en && $rose(xfer_clock)) |-> code_remote)
    else $error("transfer clock without remote source");

  strobe_capture_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
    (clk_en && state_reg == KRSW_CLKLO && stb_rise) |=>
    (shift_reg == {$past(shift_reg[KEY_W-1:0]), $past(keys_s)}))
    else $error("remote nibble not captured on strobe");

  notify_edge_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
    (clk_en && $rose(state_reg == KRSW_SETTLE)) |-> $past(notify_rise))
    else $error("sequence started without notify edge");

  valid_pulse_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
    (clk_en && code_valid) |=> !code_valid)
    else $error("valid longer than one cycle");

  key_select_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
    (state_reg == KRSW_CLKHI) |-> !source_select_output)
    else $error("selector on keys during remote transfer");

  key_cover_c: cover property (@(posedge clock) code_valid && !code_remote);
  remote_cover_c: cover property (@(posedge clock) code_valid && code_remote);
  timeout_cover_c: cover property (@(posedge clock) code_timeout);
  // a frozen cycle while the decoder is being waited on
  freeze_cover_c: cover property (@(posedge clock) !clk_en && state_reg == KRSW_CLKLO);

endmodule
`default_nettype wire

// file: tb/krsw_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module krsw_far_model
  import krsw_pkg::*;
(
  // test controls
  input  wire logic [KEY_W-1:0] key_val,
  input  wire logic             key_press,
  input  wire logic             rem_go,
  input  wire logic             rem_mute,
  input  wire logic [7:0]       rem_code,
  // pins from the controller
  input  wire logic             source_select_output,
  input  wire logic             xfer_clock,
  // pins toward the controller
  output logic                  notify_in,
  output logic                  remote_source_flag,
  output logic                  remote_timing_strobe,
  output logic [KEY_W-1:0]      key_lines
);
  int unsigned      nib_idx = 0;
  logic [KEY_W-1:0] rem_data = 4'h0;
  logic [KEY_W-1:0] pressed;
  // diode or of the pressed lines and the flag
  assign pressed = key_press ? key_val : 4'h0;
  assign notify_in = (|pressed) | remote_source_flag;
  assign key_lines = source_select_output ? pressed : rem_data;
  // flag only for codes that matched
  initial remote_source_flag = 1'b0;
  initial remote_timing_strobe = 1'b0;
  always @(posedge rem_go) begin
    nib_idx = 0;
    remote_source_flag = 1'b1;
  end
  // a muted decoder is released by the bench after the timeout
  always @(negedge rem_go) remote_source_flag = 1'b0;
  // one nibble per falling transfer clock, then the strobe
  always @(negedge xfer_clock) begin
    if (remote_source_flag && !rem_mute) begin
      rem_data = (nib_idx == 0) ? rem_code[3:0] : rem_code[7:4];
      #20 remote_timing_strobe = 1'b1;
      #60 remote_timing_strobe = 1'b0;
      rem_data = ~rem_data; // data is not held past its strobe
      nib_idx++;
      if (nib_idx == NIB_COUNT) remote_source_flag = 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: tb/key_remote_input_switching_tb.sv
`timescale 1ns/10ps
`default_nettype none
module key_remote_input_switching_tb
  import krsw_pkg::*;
;
  logic             clock = 1'b0;
  logic             rstn = 1'b0;
  logic             clk_en = 1'b1;
  logic [KEY_W-1:0] key_val = 4'h0;
  logic             key_press = 1'b0;
  logic             rem_go = 1'b0;
  logic             rem_mute = 1'b0;
  logic [7:0]       rem_code = 8'h00;
  wire logic        notify_in, remote_source_flag, remote_timing_strobe;
  wire logic [3:0]  key_lines;
  logic             source_select_output, xfer_clock, code_remote, code_valid, code_timeout;
  logic [3:0]       code_data;
  int               err_total = 0;
  int               n_compared = 0;
  int               seed = 32'h40d2;
  logic [7:0]       exp_q[$];
  logic [7:0]       seen_w;

  always #2 clock = ~clock;

  krsw_top dut (.clock(clock), .rstn(rstn), .clk_en(clk_en), .notify_in(notify_in),
    .remote_source_flag(remote_source_flag), .remote_timing_strobe(remote_timing_strobe),
    .key_lines(key_lines), .source_select_output(source_select_output), .xfer_clock(xfer_clock),
    .code_data(code_data), .code_remote(code_remote), .code_valid(code_valid), .code_timeout(code_timeout));

  krsw_far_model far (.key_val(key_val), .key_press(key_press), .rem_go(rem_go), .rem_mute(rem_mute),
    .rem_code(rem_code), .source_select_output(source_select_output), .xfer_clock(xfer_clock),
    .notify_in(notify_in), .remote_source_flag(remote_source_flag),
    .remote_timing_strobe(remote_timing_strobe), .key_lines(key_lines));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // result word: timeout, valid, select, remote, data
  assign seen_w = {code_timeout, code_valid, source_select_output, code_remote, code_timeout ? 4'h0 : code_data};

  // a pulse counts once, at the enabled edge that consumes it; a frozen pulse stands longer
  always @(posedge clock) begin
    if ((code_valid === 1'b1 || code_timeout === 1'b1) && clk_en === 1'b1) begin
      check(seen_w, exp_q.size() ? exp_q.pop_front() : 8'hff);
    end
  end

  // enable drops now and then so frozen cycles reach every state
  always @(posedge clock) clk_en <= (($random(seed) & 32'h7) != 0);

  // the selector must point at the decoder while it is clocked
  always @(posedge xfer_clock) check({7'h0, source_select_output}, 8'h00);

  // kind 0 key press, 1 remote code, 2 decoder that never strobes
  task automatic run(input int kind, input logic [7:0] c);
    int n;
    n = 0;
    if (c[3:0] == 4'h0) c[3:0] = 4'h8;
    exp_q.push_back(kind == 0 ? {4'h6, c[3:0]} : kind == 1 ? {4'h5, c[7:4]} : 8'h90);
    key_val <= c[3:0];
    key_press <= (kind == 0);
    rem_code <= c;
    rem_mute <= (kind == 2);
    rem_go <= (kind != 0);
    while (exp_q.size() != 0 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    check(8'(exp_q.size()), 8'h00);
    key_press <= 1'b0;
    rem_go <= 1'b0;
    repeat (20) @(posedge clock);
    $display("test kind %0d code %h done", kind, c);
  endtask

  initial begin
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    repeat (10) @(posedge clock);
    for (int i = 0; i < 9; i++) run(i % 3, 8'($random(seed)));
    wrap_up();
  end

  // the nine scenarios need about 5300 cycles
  initial begin
    #200000;
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire
